// ---- dcm_edge_cnt.sv ----
/*
 * Package of shared constants for the dual clock comparator, and the
 * edge-counting down-counter that sits once on each comparator side.
 * Assumes the source clock is asynchronous to i_sys_clk and at most
 * about a third of its rate, so each of its edges is seen.
 */
`timescale 1ns/1ps
package dcm_pkg;
	localparam int          DCM_CNT_W        = 20;
	localparam logic [15:0] DCM_WINDOW_W     = 16'h0004;
	localparam logic [3:0]  DCM_KEY_ENABLE   = 4'hA;
	localparam logic [3:0]  DCM_REF_FAST_CLK = 4'h5;
	localparam logic [3:0]  DCM_REF_TCK      = 4'hA;
	localparam logic [3:0]  DCM_TST_PLL      = 4'h0;
	localparam logic [3:0]  DCM_TST_RSVD     = 4'h1;
	localparam logic [3:0]  DCM_TST_LOW_PWR  = 4'h2;
	localparam logic [3:0]  DCM_TST_FAST_CLK = 4'h3;
	localparam logic [3:0]  DCM_TST_FLASH    = 4'h4;
	localparam logic [3:0]  DCM_TST_EXT_ONE  = 4'h5;
	localparam logic [3:0]  DCM_TST_EXT_TWO  = 4'h6;
	localparam logic [3:0]  DCM_TST_RING     = 4'h7;
	localparam int          DCM_SYNC_STAGES  = 2;
	localparam logic        DCM_RST_BIT      = 1'b0;

	typedef enum logic [1:0] {
		DCM_IDLE   = 2'b00,
		DCM_COUNT  = 2'b01,
		DCM_WINDOW = 2'b10,
		DCM_ERROR  = 2'b11
	} dcm_state_t;
endpackage : dcm_pkg

module dcm_edge_cnt #(
	parameter int CNT_W = dcm_pkg::DCM_CNT_W
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_clk_src,
	input  wire logic             i_load,
	input  wire logic [CNT_W-1:0] i_seed,
	input  wire logic             i_run,
	output logic      [CNT_W-1:0] o_count,
	output logic                  o_zero
);
	import dcm_pkg::*;

	logic             sync1_r, sync2_r, prev_r;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic             zero_r, zero_nxt;
	logic             edge_seen;

	// Rising edge of the source, seen only past the second stage
	assign edge_seen = sync2_r & ~prev_r;

	always_comb begin
		cnt_nxt  = cnt_r;
		zero_nxt = 1'b0;
		if (i_load) begin
			cnt_nxt = i_seed;
		end else if (i_run && edge_seen && cnt_r != '0) begin
			cnt_nxt  = cnt_r - 1'b1;
			zero_nxt = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_r <= DCM_RST_BIT;
			sync2_r <= DCM_RST_BIT;
			prev_r  <= DCM_RST_BIT;
			cnt_r   <= '0;
			zero_r  <= 1'b0;
		end else begin
			sync1_r <= i_clk_src;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
			cnt_r   <= cnt_nxt;
			zero_r  <= zero_nxt;
		end
	end

	assign o_count = cnt_r;
	assign o_zero  = zero_r;
endmodule : dcm_edge_cnt

// ---- dcm_comparator.sv ----
/*
 * Dual clock comparator: a reference side and a test side count source
 * edges down from programmed seeds; the test side must expire inside the
 * window that follows expiry of the reference side.
 * Assumes control inputs are on i_sys_clk; clock sources are asynchronous.
 */
//
// Contract
// - Two independent counters exist, counter 0 on the reference clock and counter 1 on the clock under test.
// - Each counter takes a software seed as its starting count before a run.
// - At run start both counters load their seeds together and count down on their own clock edges.
// - Counter 0 opens a window of fixed width once its seed of reference edges has elapsed.
// - Counter 1 emits a one-cycle pulse once its seed of test edges has elapsed.
// - Error is raised whenever counter 1 does not reach zero while the counter 0 window is open; here no error is raised if i_start drops first.
// - A detected mismatch drives an error output used as a processor interrupt request.
// - First comparator counter 0 source: 0x5 fast low-power oscillator, 0xA TCK, else main oscillator.
// - First comparator counter 1 with key 0xA picks PLL, reserved, low-power osc, fast clock, pump, ext1, ext2, ring, bus clock.
// - First comparator counter 1 with any key other than 0xA uses timer one channel 31 output.
// - Second comparator counter 0 source 0xA picks TCK, else main oscillator.
// - Second comparator counter 1 with key 0xA picks bus clock for 0x8-0xF, reserved below; other keys timer two channel 0.
`timescale 1ns/1ps
module dcm_comparator #(
	parameter int          COMP_ID  = 1,
	parameter int          CNT_W    = dcm_pkg::DCM_CNT_W,
	parameter logic [15:0] WINDOW_W = dcm_pkg::DCM_WINDOW_W
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_main_oscillator_input,
	input  wire logic             i_lpo_fast_clock,
	input  wire logic             i_test_clock_tck,
	input  wire logic             i_main_pll_clock,
	input  wire logic             i_low_power_oscillator,
	input  wire logic             i_flash_pump_oscillator,
	input  wire logic             i_external_clock_input_one,
	input  wire logic             i_external_clock_input_two,
	input  wire logic             i_ring_oscillator,
	input  wire logic             i_peripheral_bus_clock,
	input  wire logic             i_timer_one_channel_31_output,
	input  wire logic             i_timer_two_channel_0_output,
	input  wire logic [3:0]       i_ref_src,
	input  wire logic [3:0]       i_test_key,
	input  wire logic [3:0]       i_test_src,
	input  wire logic [CNT_W-1:0] i_ref_seed,
	input  wire logic [CNT_W-1:0] i_test_seed,
	input  wire logic             i_start,
	input  wire logic             i_err_clr,
	output logic                  o_err,
	output logic                  o_irq,
	output logic                  o_window,
	output logic                  o_busy,
	output logic                  o_pass,
	output logic                  o_test_pulse
);
	import dcm_pkg::*;

	logic             rst_s1_r, rst_s2_r;
	logic             ref_sel, test_sel;
	logic             load0, load1;
	logic [CNT_W-1:0] seed0;
	logic             run;
	logic [CNT_W-1:0] c0_cnt, c1_cnt;
	logic             c0_zero, c1_zero;
	dcm_state_t       state_r, state_nxt;
	logic             err_r, irq_r, win_r, busy_r, pass_r;
	logic             pass_nxt;
	logic [11:0]      pin_raw, pin_sync;

	// Reset release through two stages
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Pin order, low to high: main osc, fast clock, TCK, PLL, low-power osc, pump,
	// ext one, ext two, ring, bus clock, timer one, timer two
	assign pin_raw = {i_timer_two_channel_0_output, i_timer_one_channel_31_output, i_peripheral_bus_clock,
		i_ring_oscillator, i_external_clock_input_two, i_external_clock_input_one, i_flash_pump_oscillator,
		i_low_power_oscillator, i_main_pll_clock, i_test_clock_tck, i_lpo_fast_clock, i_main_oscillator_input};

	// Two flops per pin ahead of the selectors
	generate
		for (genvar gi = 0; gi < 12; gi++) begin : g_pin_sync
			logic s1_r, s2_r;
			always_ff @(posedge i_sys_clk or negedge rst_s2_r) begin
				if (!rst_s2_r) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= pin_raw[gi];
					s2_r <= s1_r;
				end
			end
			assign pin_sync[gi] = s2_r;
		end
	endgenerate

	// Source selection per comparator instance
	generate
		if (COMP_ID == 1) begin : g_first
			always_comb begin
				case (i_ref_src)
					DCM_REF_FAST_CLK: ref_sel = pin_sync[1];
					DCM_REF_TCK:      ref_sel = pin_sync[2];
					default:          ref_sel = pin_sync[0];
				endcase
			end
			always_comb begin
				if (i_test_key != DCM_KEY_ENABLE) begin
					test_sel = pin_sync[10];
				end else begin
					case (i_test_src)
						DCM_TST_PLL:      test_sel = pin_sync[3];
						DCM_TST_RSVD:     test_sel = 1'b0;
						DCM_TST_LOW_PWR:  test_sel = pin_sync[4];
						DCM_TST_FAST_CLK: test_sel = pin_sync[1];
						DCM_TST_FLASH:    test_sel = pin_sync[5];
						DCM_TST_EXT_ONE:  test_sel = pin_sync[6];
						DCM_TST_EXT_TWO:  test_sel = pin_sync[7];
						DCM_TST_RING:     test_sel = pin_sync[8];
						default:          test_sel = pin_sync[9];
					endcase
				end
			end
		end else begin : g_second
			always_comb begin
				ref_sel = (i_ref_src == DCM_REF_TCK) ? pin_sync[2] : pin_sync[0];
			end
			always_comb begin
				if (i_test_key != DCM_KEY_ENABLE) begin
					test_sel = pin_sync[11];
				end else begin
					test_sel = i_test_src[3] & pin_sync[9];
				end
			end
		end
	endgenerate

	// Reference side and test side counters
	dcm_edge_cnt #(.CNT_W(CNT_W)) u_ref_cnt (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (rst_s2_r),
		.i_clk_src (ref_sel),
		.i_load    (load0),
		.i_seed    (seed0),
		.i_run     (run),
		.o_count   (c0_cnt),
		.o_zero    (c0_zero)
	);

	dcm_edge_cnt #(.CNT_W(CNT_W)) u_test_cnt (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (rst_s2_r),
		.i_clk_src (test_sel),
		.i_load    (load1),
		.i_seed    (i_test_seed),
		.i_run     (run),
		.o_count   (c1_cnt),
		.o_zero    (c1_zero)
	);

	always_comb begin
		state_nxt = state_r;
		load0     = 1'b0;
		load1     = 1'b0;
		seed0     = i_ref_seed;
		pass_nxt  = 1'b0;
		case (state_r)
			DCM_IDLE: begin
				if (i_start) begin
					load0     = 1'b1;
					load1     = 1'b1;
					state_nxt = DCM_COUNT;
				end
			end
			DCM_COUNT: begin
				if (!i_start) begin
					state_nxt = DCM_IDLE;
				end else if (c1_zero) begin
					state_nxt = DCM_ERROR;
				end else if (c0_zero) begin
					load0     = 1'b1;
					seed0     = CNT_W'(WINDOW_W);
					state_nxt = DCM_WINDOW;
				end
			end
			DCM_WINDOW: begin
				if (!i_start) begin
					state_nxt = DCM_IDLE;
				end else if (c1_zero) begin
					load0     = 1'b1;
					load1     = 1'b1;
					pass_nxt  = 1'b1;
					state_nxt = DCM_COUNT;
				end else if (c0_zero) begin
					state_nxt = DCM_ERROR;
				end
			end
			DCM_ERROR: begin
				if (i_err_clr) begin
					state_nxt = DCM_IDLE;
				end
			end
			default: state_nxt = DCM_IDLE;
		endcase
	end

	// Counters freeze already in the deciding cycle
	assign run = (state_nxt == DCM_COUNT) || (state_nxt == DCM_WINDOW);

	always_ff @(posedge i_sys_clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			state_r <= DCM_IDLE;
			err_r   <= 1'b0;
			irq_r   <= 1'b0;
			win_r   <= 1'b0;
			busy_r  <= 1'b0;
			pass_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			err_r   <= (state_nxt == DCM_ERROR);
			irq_r   <= (state_nxt == DCM_ERROR);
			win_r   <= (state_nxt == DCM_WINDOW);
			busy_r  <= (state_nxt == DCM_COUNT) || (state_nxt == DCM_WINDOW);
			pass_r  <= pass_nxt;
		end
	end

	assign o_err        = err_r;
	assign o_irq        = irq_r;
	assign o_window     = win_r;
	assign o_busy       = busy_r;
	assign o_pass       = pass_r;
	assign o_test_pulse = c1_zero;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_s2_r);

	AST_START_LOADS: assert property (
		state_r == DCM_IDLE && i_start |=> state_r == DCM_COUNT && o_busy)
		else $error("run start did not enter counting");
	AST_SEEDS_TAKEN: assert property (
		state_r == DCM_IDLE && i_start |=> c0_cnt == $past(i_ref_seed) && c1_cnt == $past(i_test_seed))
		else $error("seeds not loaded at start");
	AST_WINDOW_OPENS: assert property (
		state_r == DCM_COUNT && i_start && c0_zero && !c1_zero
		|=> o_window && c0_cnt == CNT_W'(WINDOW_W))
		else $error("window did not open on reference expiry");
	AST_PULSE_ONE: assert property (
		c1_zero |=> !c1_zero)
		else $error("test pulse longer than one cycle");
	AST_EARLY_ERR: assert property (
		state_r == DCM_COUNT && i_start && c1_zero |=> o_err)
		else $error("test expiry before window not flagged");
	AST_LATE_ERR: assert property (
		state_r == DCM_WINDOW && i_start && c0_zero && !c1_zero |=> o_err && !o_window)
		else $error("window close without test expiry not flagged");
	AST_IRQ_WITH_ERR: assert property (
		$rose(o_err) |-> o_irq && $stable(c0_cnt))
		else $error("interrupt request not raised with error");
	AST_ERR_HOLDS: assert property (
		o_err && !i_err_clr |=> o_err && $stable(c0_cnt) && $stable(c1_cnt))
		else $error("error flag or counters moved before clear");
	AST_PASS_RELOAD: assert property (
		state_r == DCM_WINDOW && i_start && c1_zero |=> o_pass && c1_cnt == $past(i_test_seed)
		&& c0_cnt == $past(i_ref_seed))
		else $error("seeds not reloaded after passing run");
	AST_KEY_OFF_TIMER: assert property (
		i_test_key != DCM_KEY_ENABLE |-> test_sel == ((COMP_ID == 1) ? pin_sync[10] : pin_sync[11]))
		else $error("timer output not selected for foreign key");
	AST_REF_TCK: assert property (
		i_ref_src == DCM_REF_TCK |-> ref_sel == pin_sync[2])
		else $error("reference source 0xA is not TCK");

	COV_PASS: cover property (state_r == DCM_WINDOW && c1_zero ##1 o_pass);
	COV_EARLY: cover property (state_r == DCM_COUNT && c1_zero ##1 o_err);
	COV_LATE: cover property (state_r == DCM_WINDOW && c0_zero && !c1_zero ##1 o_err);
	COV_CLEAR: cover property (o_err && i_err_clr ##1 !o_err);
endmodule : dcm_comparator

// ---- dcm_src_model.sv ----
/* Clock source model: twelve oscillators sharing one phase.
 * Assumes the bench picks which sources run; a stopped source sits low. */
`timescale 1ns/1ps
module dcm_src_model (
	input  wire logic [11:0] i_run_mask,
	output logic      [11:0] o_src
);
	localparam int HALF_NS = 40;
	logic ph;
	initial begin
		ph = 1'b0;
		forever #(HALF_NS) ph = ~ph;
	end
	// Stopped sources give no edges, so a wrong select cannot count
	assign o_src = i_run_mask & {12{ph}};
endmodule : dcm_src_model

// ---- dual_clock_comparator_tb_top.sv ----
/* Self-checking bench for the dual clock comparator, both mappings.
 * Assumes all clock inputs come from the source model at one rate. */
`timescale 1ns/1ps
module dual_clock_comparator_tb_top;
	import dcm_pkg::*;
	logic                 clk;
	logic                 rstn;
	logic                 start;
	logic                 clr;
	logic [3:0]           rsrc;
	logic [3:0]           key;
	logic [3:0]           tsrc;
	logic [DCM_CNT_W-1:0] rseed;
	logic [DCM_CNT_W-1:0] tseed;
	logic [11:0]          mask;
	logic [11:0]          src;
	logic                 err;
	logic                 irq;
	logic                 win;
	logic                 busy;
	logic                 pass;
	logic                 tp;
	logic                 second;
	logic [5:0]           out_one;
	logic [5:0]           out_two;
	int                   bad_count;
	int                   total_checks;
	int                   k;

	dcm_src_model model (.i_run_mask(mask), .o_src(src));

	dcm_comparator #(.COMP_ID(1)) uut (
		.i_sys_clk(clk), .i_rstn(rstn), .i_main_oscillator_input(src[0]), .i_lpo_fast_clock(src[1]),
		.i_test_clock_tck(src[2]), .i_main_pll_clock(src[3]), .i_low_power_oscillator(src[4]),
		.i_flash_pump_oscillator(src[5]), .i_external_clock_input_one(src[6]),
		.i_external_clock_input_two(src[7]), .i_ring_oscillator(src[8]), .i_peripheral_bus_clock(src[9]),
		.i_timer_one_channel_31_output(src[10]), .i_timer_two_channel_0_output(src[11]),
		.i_ref_src(rsrc), .i_test_key(key), .i_test_src(tsrc), .i_ref_seed(rseed), .i_test_seed(tseed),
		.i_start(start & !second), .i_err_clr(clr & !second), .o_err(out_one[5]), .o_irq(out_one[4]),
		.o_window(out_one[3]), .o_busy(out_one[2]), .o_pass(out_one[1]), .o_test_pulse(out_one[0])
	);

	// Second mapping shares sources and selects; only one instance runs at a time
	dcm_comparator #(.COMP_ID(2)) uut2 (
		.i_sys_clk(clk), .i_rstn(rstn), .i_main_oscillator_input(src[0]), .i_lpo_fast_clock(src[1]),
		.i_test_clock_tck(src[2]), .i_main_pll_clock(src[3]), .i_low_power_oscillator(src[4]),
		.i_flash_pump_oscillator(src[5]), .i_external_clock_input_one(src[6]),
		.i_external_clock_input_two(src[7]), .i_ring_oscillator(src[8]), .i_peripheral_bus_clock(src[9]),
		.i_timer_one_channel_31_output(src[10]), .i_timer_two_channel_0_output(src[11]),
		.i_ref_src(rsrc), .i_test_key(key), .i_test_src(tsrc), .i_ref_seed(rseed), .i_test_seed(tseed),
		.i_start(start & second), .i_err_clr(clr & second), .o_err(out_two[5]), .o_irq(out_two[4]),
		.o_window(out_two[3]), .o_busy(out_two[2]), .o_pass(out_two[1]), .o_test_pulse(out_two[0])
	);

	assign {err, irq, win, busy, pass, tp} = second ? out_two : out_one;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// One run until pass or error, then back to idle
	task automatic run(input logic [3:0] rs, input logic [3:0] tk, input logic [3:0] ts, input logic [11:0] m,
			input logic [DCM_CNT_W-1:0] seed, input logic exp_pass, input logic exp_win);
		int   n;
		logic saw_win;
		logic saw_tp;
		n = 0;
		saw_win = 1'b0;
		saw_tp = 1'b0;
		@(negedge clk);
		rsrc = rs;
		key = tk;
		tsrc = ts;
		mask = m;
		tseed = seed;
		start = 1'b1;
		while (pass !== 1'b1 && err !== 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
			saw_win = saw_win | win;
			saw_tp = saw_tp | tp;
		end
		check(pass, exp_pass);
		check(irq, !exp_pass);
		check(saw_win, exp_win);
		check(saw_tp, exp_pass | !exp_win);
		if (exp_pass) begin
			@(negedge clk);
			check(busy, 1'b1);
			start = 1'b0;
			repeat (2) @(negedge clk);
		end else begin
			start = 1'b0;
			repeat (3) @(negedge clk);
			check(err, 1'b1);
			check(busy, 1'b0);
			clr = 1'b1;
			@(negedge clk);
			check(err, 1'b0);
			clr = 1'b0;
		end
		check(busy, 1'b0);
	endtask : run

	// Source index in the model for each test select, -1 when reserved
	function automatic int test_bit(input logic [3:0] ts);
		case (ts)
			4'h0: test_bit = 3;
			4'h1: test_bit = -1;
			4'h2: test_bit = 4;
			4'h3: test_bit = 1;
			4'h4: test_bit = 5;
			4'h5: test_bit = 6;
			4'h6: test_bit = 7;
			4'h7: test_bit = 8;
			default: test_bit = 9;
		endcase
	endfunction : test_bit

	initial begin
		bad_count = 0;
		total_checks = 0;
		rstn = 1'b0;
		start = 1'b0;
		clr = 1'b0;
		rsrc = 4'h0;
		key = DCM_KEY_ENABLE;
		tsrc = 4'h8;
		rseed = 20'h0000A;
		tseed = 20'h0000C;
		mask = 12'hFFF;
		second = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		check({out_one, out_two}, 32'h0);
		run(4'h0, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h0000C, 1'b1, 1'b1);
		run(4'h0, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h00005, 1'b0, 1'b0);
		run(4'h0, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h0001E, 1'b0, 1'b1);
		for (k = 0; k < 16; k++) begin
			if (test_bit(k[3:0]) < 0)
				run(4'h0, DCM_KEY_ENABLE, k[3:0], 12'hFFF, 20'h0000C, 1'b0, 1'b1);
			else
				run(4'h0, DCM_KEY_ENABLE, k[3:0], 12'h001 | (12'h001 << test_bit(k[3:0])), 20'h0000C, 1'b1, 1'b1);
		end
		run(4'h0, 4'h0, 4'h8, 12'h401, 20'h0000C, 1'b1, 1'b1);
		run(4'h0, 4'h5, 4'h0, 12'h401, 20'h0000C, 1'b1, 1'b1);
		run(4'h5, DCM_KEY_ENABLE, 4'h8, 12'h202, 20'h0000C, 1'b1, 1'b1);
		run(4'hA, DCM_KEY_ENABLE, 4'h8, 12'h204, 20'h0000C, 1'b1, 1'b1);
		run(4'h3, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h0000C, 1'b1, 1'b1);
		// Shorter reference seed moves the window ahead of the test expiry
		rseed = 20'h00006;
		run(4'h0, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h0000C, 1'b0, 1'b1);
		rseed = 20'h0000A;
		second = 1'b1;
		run(4'hA, DCM_KEY_ENABLE, 4'h8, 12'h204, 20'h0000C, 1'b1, 1'b1);
		run(4'h5, DCM_KEY_ENABLE, 4'h8, 12'h201, 20'h0000C, 1'b1, 1'b1);
		run(4'h0, DCM_KEY_ENABLE, 4'h3, 12'hFFF, 20'h0000C, 1'b0, 1'b1);
		run(4'h0, DCM_KEY_ENABLE, 4'hF, 12'h201, 20'h0000C, 1'b1, 1'b1);
		run(4'h0, 4'h0, 4'h0, 12'h801, 20'h0000C, 1'b1, 1'b1);
		run(4'h0, 4'h0, 4'h8, 12'h401, 20'h0000C, 1'b0, 1'b1);
		report_and_stop();
	end

	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
endmodule : dual_clock_comparator_tb_top
